// >>> ccss_edge.sv
`timescale 1ns/100ps
// two-flop synchroniser followed by a rising edge pulse
module ccss_edge
(
    input  wire logic CLOCK,
    input  wire logic SRST,
    input  wire logic ASYNC_IN,
    output logic      RISE
);

    typedef struct packed {
        logic meta;    // first stage, read only by the second
        logic sync;    // second stage
        logic last;    // previous synced level
        logic rise;    // registered edge pulse
    } ccss_edge_t;

    ccss_edge_t r;       // registered state
    ccss_edge_t next_r;  // next state

    // shift the pin in and flag a low-to-high change
    always_comb
    begin
        next_r      = r;
        next_r.meta = ASYNC_IN;
        next_r.sync = r.meta;
        next_r.last = r.sync;
        next_r.rise = r.sync & ~r.last;
    end

    always_ff @(posedge CLOCK)
    begin
        if (SRST)
            r <= '{meta: 1'b1, sync: 1'b1, last: 1'b1, rise: 1'b0};  // high: pin must fall first
        else
            r <= next_r;
    end

    assign RISE = r.rise;

endmodule

// >>> ccss_osc_model.sv
`timescale 1ns/100ps
// oscillators and external clock seen by the start-up block
module ccss_osc_model
#(
    parameter real SRC_HALF  = 30.0,   // half period of every source, ns
    parameter real WDOG_HALF = 40.0    // watchdog oscillator runs apart from the sources
)
(
    input  wire logic ext_run,         // external clock driven only while it is the source
    output logic      lfxo,
    output logic      rc,
    output logic      lp128,
    output logic      wdog,
    output logic      xin
);
    logic src_wave = 1'b0;             // one wave shared by the internal sources
    logic wdog_wave = 1'b0;            // slower wave so its ticks are told apart

    // free-running waves, each at least two system clocks per level
    always #(SRC_HALF) src_wave = ~src_wave;
    always #(WDOG_HALF) wdog_wave = ~wdog_wave;

    assign lfxo  = src_wave;
    assign rc    = src_wave;
    assign lp128 = src_wave;
    assign wdog  = wdog_wave;
    // pin stands still low when nobody drives a clock onto it
    assign xin   = ext_run ? src_wave : 1'b0;
endmodule

// >>> ccss_pkg.sv
// Notes on behaviour
// R1: watch crystal wake waits 1K or 32K
// R2: watch crystal reset adds 14CK, 4.1ms, 65ms
// R3: source fuses 0010 select internal RC
// R4: blank fuses give RC, slow power, div8
// R5: RC waits 6CK; reset 14CK plus delays
// R6: reset loads factory byte into trim
// R7: software reads and writes all trim bits
// R8: trim top bit picks overlapping range
// R9: low seven trim bits tune monotonically
// R10: reset time-out runs on watchdog oscillator
// R11: software keeps RC below 8.8 MHz writing
// R12: source fuses 0011 select 128 kHz oscillator
// R13: 128k waits 6CK; reset adds 4/64 ms
// R14: fuses 0000 take external clock pin
// R15: external clock start-up from startup fuses only
// R16: system clock gated until counts elapse
// R17: reserved fuse codes never start clock
package ccss_pkg;

    // clock source fuse codes
    localparam logic [3:0] FUSE_SRC_EXT   = 4'h0;          // external clock on crystal pin
    localparam logic [3:0] FUSE_SRC_RC    = 4'h2;          // calibrated internal rc
    localparam logic [3:0] FUSE_SRC_LP128 = 4'h3;          // 128 khz internal oscillator
    localparam logic [2:0] FUSE_SRC_LFXO  = 3'h2;          // upper three bits, watch crystal

    // start-up time fuse codes
    localparam logic [1:0] SUT_NONE     = 2'h0;            // 14 cycles only
    localparam logic [1:0] SUT_SHORT    = 2'h1;            // plus short time-out
    localparam logic [1:0] SUT_LONG     = 2'h2;            // plus long time-out
    localparam logic [1:0] SUT_RESERVED = 2'h3;            // not a valid setting

    // delivered fuse state, used when the fuse array reports blank
    localparam logic [3:0] DEFAULT_SRC  = FUSE_SRC_RC;
    localparam logic [1:0] DEFAULT_SUT  = SUT_LONG;
    localparam logic       DEFAULT_DIV8 = 1'b1;

    // source cycle counts
    localparam int          COUNT_W          = 17;
    localparam logic [16:0] LFXO_SHORT_CYC   = 17'h00400;  // 1k cycles
    localparam int          LFXO_LONG_CYC    = 32768;      // 32k cycles
    localparam logic [16:0] INTERNAL_CYC     = 17'h00006;  // rc, 128k and external
    localparam logic [16:0] RESET_EXTRA_CYC  = 17'h0000e;  // 14 cycles after reset

    // reset time-out figures, in microseconds, counted on watchdog oscillator
    localparam longint WDOG_HZ    = 128000;
    localparam longint T_SHORT_US = 4100;
    localparam longint T_LONG_US  = 65000;
    localparam longint T_LP_SHORT_US = 4000;
    localparam longint T_LP_LONG_US  = 64000;
    localparam longint US_PER_S   = 1000000;
    // least times round up to whole oscillator ticks
    localparam int T_SHORT_TICKS    = int'((T_SHORT_US * WDOG_HZ + US_PER_S - 1) / US_PER_S);
    localparam int T_LONG_TICKS     = int'((T_LONG_US * WDOG_HZ + US_PER_S - 1) / US_PER_S);
    localparam int T_LP_SHORT_TICKS = int'((T_LP_SHORT_US * WDOG_HZ + US_PER_S - 1) / US_PER_S);
    localparam int T_LP_LONG_TICKS  = int'((T_LP_LONG_US * WDOG_HZ + US_PER_S - 1) / US_PER_S);

    // source select encoding on the output
    localparam logic [1:0] SRC_EXT   = 2'h0;
    localparam logic [1:0] SRC_LFXO  = 2'h1;
    localparam logic [1:0] SRC_RC    = 2'h2;
    localparam logic [1:0] SRC_LP128 = 2'h3;

    // register byte offsets
    localparam logic [7:0] TRIM_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] FUSE_OFS   = 8'h08;

    // status and fuse word field positions
    localparam int ST_CLKEN_BIT = 0;
    localparam int ST_BAD_BIT   = 1;
    localparam int ST_STATE_LSB = 2;
    localparam int ST_SRC_LSB   = 5;
    localparam int ST_DIV8_BIT  = 7;
    localparam int FU_SUT_LSB   = 4;

    // start-up sequencer states
    typedef enum logic [2:0] {
        ST_TIMEOUT = 3'b000,   // reset time-out on watchdog ticks
        ST_START   = 3'b001,   // counting source cycles
        ST_RUN     = 3'b010,   // system clock on
        ST_SLEEP   = 3'b011,   // power-down or power-save
        ST_WAKE    = 3'b100,   // counting wake cycles
        ST_BAD     = 3'b101    // reserved fuse setting
    } ccss_state_t;

endpackage

// >>> ccss_props.sv
`timescale 1ns/100ps
// port-level checks of the clock start-up block
module ccss_props
(
    input wire logic        CLOCK,
    input wire logic        SRST,
    input wire logic [3:0]  CLOCK_SOURCE_SELECT_FUSES,
    input wire logic [1:0]  STARTUP_TIME_FUSES,
    input wire logic        DIVIDE_BY_EIGHT_FUSE,
    input wire logic        FUSES_BLANK,
    input wire logic [7:0]  FACTORY_CAL,
    input wire logic        SLEEP_REQ,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic        SYSTEM_CLOCK_ENABLE,
    input wire logic [1:0]  SOURCE_SELECT,
    input wire logic        CONFIG_INVALID,
    input wire logic        PRESCALE_DIV8,
    input wire logic [7:0]  RC_OSCILLATOR_TRIM
);
    logic take_trim, wr_trim, rd_trim;  // trim address phase, write and read data phases

    assign take_trim = HSEL && HTRANS[1] && HREADY && (HADDR[7:0] == ccss_pkg::TRIM_OFS);

    // follow trim accesses into their data phase
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            wr_trim <= 1'b0;
            rd_trim <= 1'b0;
        end
        else
        begin
            wr_trim <= take_trim && HWRITE;
            rd_trim <= take_trim && !HWRITE;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (SRST);

    bus_okay_a: assert property (HREADYOUT && !HRESP)
        else $error("bus answer not ready or not okay");
    reset_trim_a: assert property (disable iff (1'b0) SRST |=> RC_OSCILLATOR_TRIM == $past(FACTORY_CAL))
        else $error("trim not loaded with factory byte in reset");
    reset_gate_a: assert property (disable iff (1'b0) SRST |=> !SYSTEM_CLOCK_ENABLE)
        else $error("system clock released during reset");
    trim_write_a: assert property (wr_trim |=> RC_OSCILLATOR_TRIM == $past(HWDATA[7:0]))
        else $error("trim write not taken");
    trim_read_a: assert property (rd_trim |-> HRDATA == {24'h000000, RC_OSCILLATOR_TRIM})
        else $error("trim read returns wrong value");
    invalid_gate_a: assert property (CONFIG_INVALID |-> !SYSTEM_CLOCK_ENABLE)
        else $error("clock released on reserved fuses");
    bad_fuse_a: assert property ($fell(SRST) && !FUSES_BLANK
        && STARTUP_TIME_FUSES == ccss_pkg::SUT_RESERVED |=> CONFIG_INVALID)
        else $error("reserved start-up code not flagged");
    sleep_gate_a: assert property ($rose(SLEEP_REQ) && SYSTEM_CLOCK_ENABLE
        |=> !SYSTEM_CLOCK_ENABLE)
        else $error("clock not gated on sleep");
    div8_latch_a: assert property ($fell(SRST) |-> PRESCALE_DIV8
        == (FUSES_BLANK ? ccss_pkg::DEFAULT_DIV8 : DIVIDE_BY_EIGHT_FUSE))
        else $error("divide by eight fuse not latched");
    rc_pick_a: assert property (FUSES_BLANK
        || CLOCK_SOURCE_SELECT_FUSES == ccss_pkg::FUSE_SRC_RC |-> SOURCE_SELECT == ccss_pkg::SRC_RC)
        else $error("rc source not selected");
    lp_pick_a: assert property (!FUSES_BLANK
        && CLOCK_SOURCE_SELECT_FUSES == ccss_pkg::FUSE_SRC_LP128
        |-> SOURCE_SELECT == ccss_pkg::SRC_LP128)
        else $error("128 khz source not selected");
endmodule

bind ccss_top ccss_props chk (.*);

// >>> ccss_top.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// clock source selection, start-up delay and rc trim register
module ccss_top
#(
    parameter int LFXO_LONG_CYC   = ccss_pkg::LFXO_LONG_CYC,   // 32k wake cycles
    parameter int LONG_TICKS      = ccss_pkg::T_LONG_TICKS,    // 65 ms time-out
    parameter int LP_LONG_TICKS   = ccss_pkg::T_LP_LONG_TICKS  // 64 ms time-out
)
(
    input  wire logic        CLOCK,
    input  wire logic        SRST,
    // fuse array, static, same domain
    input  wire logic [3:0]  CLOCK_SOURCE_SELECT_FUSES,
    input  wire logic [1:0]  STARTUP_TIME_FUSES,
    input  wire logic        DIVIDE_BY_EIGHT_FUSE,
    input  wire logic        FUSES_BLANK,
    input  wire logic [7:0]  FACTORY_CAL,
    // oscillator outputs and clock pin, all asynchronous
    input  wire logic        CRYSTAL_INPUT_PIN,
    input  wire logic        LFXO_OSC,
    input  wire logic        RC_OSC,
    input  wire logic        LP128_OSC,
    input  wire logic        WDOG_OSC,
    // sleep request from the power manager
    input  wire logic        SLEEP_REQ,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // clock control outputs
    output logic             SYSTEM_CLOCK_ENABLE,
    output logic [1:0]       SOURCE_SELECT,
    output logic             CONFIG_INVALID,
    output logic             PRESCALE_DIV8,
    output logic [7:0]       RC_OSCILLATOR_TRIM
);

    localparam int NSRC = 5;   // pins passed through synchronisers

    typedef struct packed {
        ccss_pkg::ccss_state_t state;    // sequencer state
        logic [16:0]           count;    // cycles or ticks counted so far
        logic [7:0]            trim;     // rc trim register
        logic [3:0]            src_fuse; // latched source fuses
        logic [1:0]            sut_fuse; // latched start-up fuses
        logic                  div8;     // latched divide-by-eight fuse
        logic                  bad;      // reserved setting seen
        logic                  clk_en;   // system clock gate
        logic                  wr_trim;  // write to trim in data phase
        logic [31:0]           rdata;    // read data for the data phase
    } ccss_regs_t;

    ccss_regs_t r;       // registered state
    ccss_regs_t next_r;  // next state

    logic [NSRC-1:0] src_pin;     // raw source pins
    logic [NSRC-1:0] src_rise;    // synced rising edges
    logic            src_tick;    // edge of the selected source
    logic            wdog_tick;   // edge of the watchdog oscillator
    logic [1:0]      src_code;    // decoded source
    logic            src_ok;      // source code is supported
    logic            sut_ok;      // start-up code is not reserved
    logic [16:0]     wake_cyc;    // wake count for the source
    logic [16:0]     tout_ticks;  // reset time-out ticks
    logic            addr_phase;  // ahb address phase accepted
    logic [7:0]      addr_ofs;    // low address byte
    logic [7:0]      trim_now;    // trim with a pending write merged

    // every source pin is resynchronised before it is counted
    assign src_pin = {WDOG_OSC, LP128_OSC, RC_OSC, LFXO_OSC, CRYSTAL_INPUT_PIN};

    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++)
        begin : g_sync
            ccss_edge u_edge
            (
                .CLOCK    (CLOCK),
                .SRST     (SRST),
                .ASYNC_IN (src_pin[gi]),
                .RISE     (src_rise[gi])
            );
        end
    endgenerate

    // the reset time-out runs on watchdog ticks whatever source is chosen
    assign wdog_tick = src_rise[4];  // see R10

    // decode the latched source fuses
    always_comb
    begin
        src_code = ccss_pkg::SRC_EXT;
        src_ok   = 1'b1;
        if (r.src_fuse == ccss_pkg::FUSE_SRC_EXT)
            src_code = ccss_pkg::SRC_EXT;    // see R14
        else if (r.src_fuse == ccss_pkg::FUSE_SRC_RC)
            src_code = ccss_pkg::SRC_RC;     // see R3
        else if (r.src_fuse == ccss_pkg::FUSE_SRC_LP128)
            src_code = ccss_pkg::SRC_LP128;  // see R12
        else if (r.src_fuse[3:1] == ccss_pkg::FUSE_SRC_LFXO)
            src_code = ccss_pkg::SRC_LFXO;
        else
            src_ok   = 1'b0;                 // other crystal modes are not built here
    end

    assign sut_ok = (r.sut_fuse != ccss_pkg::SUT_RESERVED);  // see R17

    // pick the edge stream of the selected source
    always_comb
    begin
        case (src_code)
            ccss_pkg::SRC_EXT:   src_tick = src_rise[0];
            ccss_pkg::SRC_LFXO:  src_tick = src_rise[1];
            ccss_pkg::SRC_RC:    src_tick = src_rise[2];
            ccss_pkg::SRC_LP128: src_tick = src_rise[3];
            default:             src_tick = 1'b0;
        endcase
    end

    // wake count per source; only the watch crystal uses bit zero
    always_comb
    begin
        if (src_code == ccss_pkg::SRC_LFXO)
        begin
            if (r.src_fuse[0])
                wake_cyc = LFXO_LONG_CYC[16:0];        // see R1
            else
                wake_cyc = ccss_pkg::LFXO_SHORT_CYC;   // see R1
        end
        else
        begin
            // rc, 128k and external share six cycles, external by start-up fuses only
            wake_cyc = ccss_pkg::INTERNAL_CYC;         // see R5 // see R13 // see R15
        end
    end

    // reset time-out per start-up code; 128k uses its own figures
    always_comb
    begin
        case (r.sut_fuse)
            ccss_pkg::SUT_SHORT:
            begin
                if (src_code == ccss_pkg::SRC_LP128)
                    tout_ticks = ccss_pkg::T_LP_SHORT_TICKS[16:0];  // see R13
                else
                    tout_ticks = ccss_pkg::T_SHORT_TICKS[16:0];     // see R2 // see R5
            end
            ccss_pkg::SUT_LONG:
            begin
                if (src_code == ccss_pkg::SRC_LP128)
                    tout_ticks = LP_LONG_TICKS[16:0];               // see R13
                else
                    tout_ticks = LONG_TICKS[16:0];                  // see R2 // see R5
            end
            default:
                tout_ticks = '0;   // 14 cycles only, no time-out
        endcase
    end

    // ahb-lite address phase; hsize is ignored, whole words only
    assign addr_phase = HSEL & HTRANS[1] & HREADY;
    assign addr_ofs   = HADDR[7:0];
    // a read right behind a trim write sees the new value
    assign trim_now   = r.wr_trim ? HWDATA[7:0] : r.trim;

    // sequencer, register file and bus slave
    always_comb
    begin
        next_r = r;

        // data phase of a trim write; every bit is writable
        next_r.wr_trim = 1'b0;
        if (r.wr_trim)
            next_r.trim = HWDATA[7:0];  // see R7 // see R8 // see R9

        // address phase: note the write, prepare the read word
        next_r.rdata = '0;
        if (addr_phase)
        begin
            if (HWRITE)
                next_r.wr_trim = (addr_ofs == ccss_pkg::TRIM_OFS);
            else
            begin
                case (addr_ofs)
                    ccss_pkg::TRIM_OFS:
                        next_r.rdata[7:0] = trim_now;  // see R7
                    ccss_pkg::STATUS_OFS:
                    begin
                        next_r.rdata[ccss_pkg::ST_CLKEN_BIT] = r.clk_en;
                        next_r.rdata[ccss_pkg::ST_BAD_BIT]   = r.bad;
                        next_r.rdata[ccss_pkg::ST_STATE_LSB +: 3] = r.state;
                        next_r.rdata[ccss_pkg::ST_SRC_LSB +: 2]   = src_code;
                        next_r.rdata[ccss_pkg::ST_DIV8_BIT]  = r.div8;
                    end
                    ccss_pkg::FUSE_OFS:
                    begin
                        next_r.rdata[3:0] = r.src_fuse;
                        next_r.rdata[ccss_pkg::FU_SUT_LSB +: 2] = r.sut_fuse;
                    end
                    default:
                        next_r.rdata = '0;  // unmapped reads return zero
                endcase
            end
        end

        // start-up sequencer
        case (r.state)
            ccss_pkg::ST_TIMEOUT:
            begin
                // reserved settings never start the clock
                if (!src_ok || !sut_ok)
                begin
                    next_r.state = ccss_pkg::ST_BAD;  // see R17
                    next_r.bad   = 1'b1;
                end
                else if (r.count >= tout_ticks)
                begin
                    next_r.state = ccss_pkg::ST_START;
                    next_r.count = '0;
                end
                else if (wdog_tick)
                    next_r.count = r.count + 17'h00001;  // see R10
            end
            ccss_pkg::ST_START:
            begin
                // source cycles plus the fixed 14 before release
                if (r.count >= wake_cyc + ccss_pkg::RESET_EXTRA_CYC)
                begin
                    next_r.state  = ccss_pkg::ST_RUN;
                    next_r.clk_en = 1'b1;  // see R16
                end
                else if (src_tick)
                    next_r.count = r.count + 17'h00001;  // see R16
            end
            ccss_pkg::ST_RUN:
            begin
                if (SLEEP_REQ)
                begin
                    next_r.state  = ccss_pkg::ST_SLEEP;
                    next_r.clk_en = 1'b0;
                end
            end
            ccss_pkg::ST_SLEEP:
            begin
                // the oscillator may stop here, so the count restarts on wake
                next_r.count = '0;
                if (!SLEEP_REQ)
                    next_r.state = ccss_pkg::ST_WAKE;
            end
            ccss_pkg::ST_WAKE:
            begin
                // wake waits only the source cycles, no time-out
                if (SLEEP_REQ)
                    next_r.state = ccss_pkg::ST_SLEEP;
                else if (r.count >= wake_cyc)
                begin
                    next_r.state  = ccss_pkg::ST_RUN;
                    next_r.clk_en = 1'b1;  // see R16
                end
                else if (src_tick)
                    next_r.count = r.count + 17'h00001;  // see R1 // see R5 // see R13
            end
            ccss_pkg::ST_BAD:
            begin
                // stays gated until the next reset with valid fuses
                next_r.clk_en = 1'b0;  // see R17
            end
            default:
            begin
                next_r.state  = ccss_pkg::ST_BAD;
                next_r.clk_en = 1'b0;
            end
        endcase
    end

    // synchronous reset latches the fuses and reloads the factory trim
    always_ff @(posedge CLOCK)
    begin
        if (SRST)
        begin
            r.state  <= ccss_pkg::ST_TIMEOUT;
            r.count  <= '0;
            r.trim   <= FACTORY_CAL;  // see R6
            r.bad    <= 1'b0;
            r.clk_en <= 1'b0;         // see R16
            r.wr_trim <= 1'b0;
            r.rdata  <= '0;
            if (FUSES_BLANK)
            begin
                // delivered part: rc, slow rising power, divide by eight
                r.src_fuse <= ccss_pkg::DEFAULT_SRC;   // see R4
                r.sut_fuse <= ccss_pkg::DEFAULT_SUT;   // see R4
                r.div8     <= ccss_pkg::DEFAULT_DIV8;  // see R4
            end
            else
            begin
                r.src_fuse <= CLOCK_SOURCE_SELECT_FUSES;
                r.sut_fuse <= STARTUP_TIME_FUSES;
                r.div8     <= DIVIDE_BY_EIGHT_FUSE;
            end
        end
        else
            r <= next_r;
    end

    // the slave never stretches and never errors
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    assign HRDATA    = r.rdata;

    // outputs to the clock tree and oscillators
    assign SYSTEM_CLOCK_ENABLE = r.clk_en;
    assign SOURCE_SELECT       = src_code;
    assign CONFIG_INVALID      = r.bad;
    assign PRESCALE_DIV8       = r.div8;
    // the trim goes straight to the rc oscillator; a write retunes it at once
    assign RC_OSCILLATOR_TRIM  = r.trim;  // see R7 // see R8

endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
// register and start-up sequence tests for the clock start-up block
module tb_top;
    localparam int LFXO_CYC = 64;      // shortened 32k wake count
    localparam int LONG_T   = 20;      // shortened long time-out ticks
    localparam int LP_T     = 16;      // shortened 128k long time-out ticks
    localparam int SRC_P    = 6;       // source period in system clocks
    localparam int WDG_P    = 8;       // watchdog period in system clocks

    logic clock = 1'b0, srst = 1'b1;
    logic [3:0] src_f = 4'h2;          // source fuses
    logic [1:0] sut_f = 2'h0;          // start-up fuses
    logic div8_f = 1'b0;
    logic blank = 1'b0;
    logic [7:0] cal = 8'h5a;           // factory byte, arbitrary
    logic sleep_req = 1'b0;
    logic ext_run = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic lfxo, rc, lp128, wdog, xin, sys_en, bad, div8;
    logic [1:0] src_sel;
    logic [7:0] trim;
    int n_fail = 0, n_compared = 0;
    // no memory writes run here, so trims above the safe limit may be tried
    logic [7:0] vals [4] = '{8'h7f, 8'h80, 8'h00, 8'hff};

    always #5 clock = ~clock;

    ccss_osc_model osc (.ext_run(ext_run), .lfxo(lfxo), .rc(rc), .lp128(lp128), .wdog(wdog),
        .xin(xin));
    ccss_top #(.LFXO_LONG_CYC(LFXO_CYC), .LONG_TICKS(LONG_T), .LP_LONG_TICKS(LP_T)) dut (
        .CLOCK(clock), .SRST(srst), .CLOCK_SOURCE_SELECT_FUSES(src_f),
        .STARTUP_TIME_FUSES(sut_f), .DIVIDE_BY_EIGHT_FUSE(div8_f), .FUSES_BLANK(blank),
        .FACTORY_CAL(cal), .CRYSTAL_INPUT_PIN(xin), .LFXO_OSC(lfxo), .RC_OSC(rc),
        .LP128_OSC(lp128), .WDOG_OSC(wdog), .SLEEP_REQ(sleep_req), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .SYSTEM_CLOCK_ENABLE(sys_en), .SOURCE_SELECT(src_sel), .CONFIG_INVALID(bad),
        .PRESCALE_DIV8(div8), .RC_OSCILLATOR_TRIM(trim));

    // prints the verdict and stops the run
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // one comparison with four-state equality
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_fail++;
        end
    endtask

    // waits for an edge with ready high; a stall past the bound ends the run
    task automatic ready_edge;
        repeat (16)
        begin
            @(posedge clock);
            if (hreadyout === 1'b1)
                return;
        end
        $display("[FAIL] bus ready expected 1 seen stall");
        n_fail++;
        end_of_test();
    endtask

    // single word transfer: address phase, then data phase; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        ready_edge();
        htrans <= 2'h0;
        hwdata <= wd;
        ready_edge();
        rd = hrdata;
    endtask

    // counts clocks until the system clock is released; hi of zero means never
    task automatic wait_en(input int lo, input int hi);
        int c;
        c = 0;
        while (sys_en !== 1'b1 && c < hi + 400)
        begin
            @(posedge clock);
            c++;
        end
        n_compared++;
        if ((hi == 0 && c < 400) || (hi > 0 && (c < lo || c > hi)))
        begin
            $display("[FAIL] release cycles expected %0d..%0d seen %0d", lo, hi, c);
            n_fail++;
            // a release that never came ends the run here
            if (hi > 0 && sys_en !== 1'b1)
                end_of_test();
        end
    endtask

    // reset with given fuses, then time the release; the first tick may follow release at once
    task automatic startup(input logic [3:0] s, input logic [1:0] t, input logic b,
                           input int ticks, input int edges);
        src_f <= s;
        sut_f <= t;
        blank <= b;
        ext_run <= (s == 4'h0);
        srst <= 1'b1;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        if (edges == 0)
            wait_en(0, 0);
        else
            wait_en((ticks > 0 ? ticks - 1 : 0) * WDG_P + (edges - 1) * SRC_P,
                    ticks * WDG_P + edges * SRC_P + 16);
        if (edges == 0)
            check("config invalid", 32'h1, {31'h0, bad});
        $display("start-up test done fuses %h %h", s, t);
    endtask

    // sleep gates the clock at once; wake counts only the wake cycles
    task automatic sleep_wake(input int edges);
        sleep_req <= 1'b1;
        repeat (2) @(posedge clock);
        check("sleep gate", 32'h0, {31'h0, sys_en});
        repeat (50) @(posedge clock);
        sleep_req <= 1'b0;
        wait_en((edges - 1) * SRC_P, edges * SRC_P + 16);
        $display("wake test done %0d cycles", edges);
    endtask

    initial
    begin
        // blank fuses fall back to delivered defaults
        startup(4'h3, 2'h0, 1'b1, LONG_T, 20);
        check("div8 default", 32'h1, {31'h0, div8});
        check("default source", {30'h0, ccss_pkg::SRC_RC}, {30'h0, src_sel});
        check("trim reset", {24'h0, cal}, {24'h0, trim});
        bus(1'b0, ccss_pkg::TRIM_OFS, 32'h0);
        check("trim read", {24'h0, cal}, rd);
        foreach (vals[i])
        begin
            bus(1'b1, ccss_pkg::TRIM_OFS, {24'h0, vals[i]});
            bus(1'b0, ccss_pkg::TRIM_OFS, 32'h0);
            check("trim word", {24'h0, vals[i]}, rd);
            check("trim port", {24'h0, vals[i]}, {24'h0, trim});
        end
        bus(1'b1, ccss_pkg::STATUS_OFS, 32'hffffffff);
        bus(1'b0, ccss_pkg::STATUS_OFS, 32'h0);
        check("status", 32'h000000c9, rd);
        bus(1'b0, 8'h0c, 32'h0);
        check("unmapped", 32'h0, rd);
        $display("register test done");
        startup(4'h2, 2'h0, 1'b0, 0, 20);
        sleep_wake(6);
        startup(4'h2, 2'h1, 1'b0, ccss_pkg::T_SHORT_TICKS, 20);
        startup(4'h3, 2'h2, 1'b0, LP_T, 20);
        sleep_wake(6);
        startup(4'h3, 2'h1, 1'b0, ccss_pkg::T_LP_SHORT_TICKS, 20);
        startup(4'h0, 2'h2, 1'b0, LONG_T, 20);
        sleep_wake(6);
        startup(4'h4, 2'h0, 1'b0, 0, 1024 + 14);
        startup(4'h5, 2'h2, 1'b0, LONG_T, LFXO_CYC + 14);
        sleep_wake(LFXO_CYC);
        startup(4'h2, 2'h3, 1'b0, 0, 0);
        startup(4'h4, 2'h3, 1'b0, 0, 0);
        startup(4'h1, 2'h0, 1'b0, 0, 0);
        end_of_test();
    end
endmodule
